/* core/bts_carrier_if.sv */
// carrier control bundle between sequencer and phase accumulator
`timescale 1ns/10ps
interface bts_carrier_if;
  logic load;
  logic run;
  logic [31:0] phase;
  logic [31:0] step;
  logic wrap;
  logic [31:0] sample;
  modport seq (output load, run, phase, step, input wrap, sample);
  modport acc (input load, run, phase, step, output wrap, sample);
endinterface // bts_carrier_if

/* core/bts_phase_acc.sv */
// carrier phase accumulator with cycle wrap pulse
`timescale 1ns/10ps
module bts_phase_acc
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // carrier control
  bts_carrier_if.acc car
);

  logic [31:0] acc;
  logic [31:0] base;
  logic [32:0] sum;

  assign sum = {1'b0, acc} + {1'b0, car.step};

  // acc counts from zero at each head, so a carry marks a whole cycle
  // whatever the start phase; base adds the start phase back on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc <= 32'h0;
      base <= 32'h0;
    end
    else if (car.load)
    begin
      acc <= 32'h0;
      base <= car.phase;
    end
    else if (car.run)
    begin
      acc <= sum[31:0];
    end
  end

  // sample is the phase word; waveform lookup lives downstream
  assign car.sample = acc + base;
  // carry of the step that closes a cycle: the sample now shown is the
  // last one of that cycle, so stopping here keeps cycles whole
  assign car.wrap = car.run && sum[32];

endmodule // bts_phase_acc

/* core/bts_pkg.sv */
// constants, register map and types of the burst trigger sequencer
package bts_pkg;

  // ***********************
  // register byte offsets
  // ***********************
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] ncyc_off = 12'h004;
  localparam logic [11:0] per_off = 12'h008;
  localparam logic [11:0] dly_off = 12'h00c;
  localparam logic [11:0] cnt_off = 12'h010;
  localparam logic [11:0] phase_off = 12'h014;
  localparam logic [11:0] offs_off = 12'h018;
  localparam logic [11:0] mtrig_off = 12'h01c;
  localparam logic [11:0] stat_off = 12'h020;

  // ***********************
  // control register fields
  // ***********************
  localparam int ctrl_en_bit = 0;
  localparam int ctrl_gated_bit = 1;
  localparam int ctrl_src_lsb = 2;
  localparam int ctrl_gpol_bit = 4;
  localparam int ctrl_fall_bit = 5;
  localparam int ctrl_tout_lsb = 6;
  localparam int ctrl_hold_lsb = 8;
  localparam int ctrl_inf_bit = 10;

  // ***********************
  // reset values
  // ***********************
  localparam logic [31:0] ctrl_rst = 32'h0000_0000;
  localparam logic [31:0] ncyc_rst = 32'h0000_0001;
  localparam logic [31:0] per_rst = 32'h0000_03e8;
  localparam logic [31:0] cnt_rst = 32'h0000_0001;

  // ***********************
  // timing
  // ***********************
  localparam int clk_mhz = 50;
  localparam int min_lat_ns = 100;
  // least time rounds up to whole cycles
  localparam int min_lat_cyc = (min_lat_ns * clk_mhz + 999) / 1000;
  localparam logic [31:0] min_dly = 32'(min_lat_cyc);

  // ***********************
  // types
  // ***********************
  typedef enum logic [1:0] {src_int, src_ext, src_man} bts_src_t;
  typedef enum logic [1:0] {tout_off, tout_up, tout_down} bts_tout_t;
  typedef enum logic [1:0] {hold_start, hold_end, hold_mid} bts_hold_t;
  typedef enum {st_idle, st_delay, st_burst, st_gap} bts_state_t;

endpackage // bts_pkg

/* core/bts_sequencer.sv */
// burst trigger sequencer top with apb register file
// How it works
// - counted bursts emit a set number of whole cycles, gated bursts run only while the gate is active.
// - the internal source starts bursts from a timer spaced by the burst period.
// - the external trigger source launches one sequence per qualifying edge seen while idle.
// - the external gate source uses the input level to decide carrier output.
// - each manual trigger request made while idle launches exactly one burst sequence; requests while busy are ignored.
// - every burst starts with the carrier at the programmed start phase.
// - only the counted type uses the cycle count setting.
// - an infinite cycle count runs the carrier continuously after a trigger.
// - several trains from one trigger are spaced by the burst period.
// - positive gate polarity passes while high, negative while low.
// - a programmable delay precedes the burst, clamped to the least latency.
// - with internal or manual source a trigger output is up, down or off.
// - the trigger output edge coincides with the sequence start.
// - with external source a setting picks rising or falling edge.
// - between bursts the output holds start sample, end sample or offset.
`timescale 1ns/10ps
module bts_sequencer
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  input wire logic ext_in,
  input wire logic [31:0] carrier_step,
  output logic [31:0] wave_out,
  output logic wave_active,
  output logic trig_out
);

  // *************************
  // registers
  // *************************
  logic [31:0] ctrl, ncyc, per, dly, cnt, phase, offs;
  logic man_req;
  bts_pkg::bts_state_t state;
  logic [31:0] cyc_left, trains_left, tmr, per_tmr;
  logic ext_q, gate_on, trig_ev, busy, wr, rd, hit;
  logic [31:0] end_sample;
  bts_pkg::bts_src_t src;
  bts_pkg::bts_tout_t tmode;
  bts_pkg::bts_hold_t hmode;
  logic gated, infinite, seq_start;

  bts_carrier_if car ();

  bts_phase_acc u_acc
  (
    .pclk(pclk),
    .presetn(presetn),
    .car(car)
  );

  function automatic logic [31:0] dec(input logic [31:0] v);
    dec = (v == 32'h0) ? 32'h0 : v - 32'h1;
  endfunction

  assign src = bts_pkg::bts_src_t'(ctrl[bts_pkg::ctrl_src_lsb +: 2]);
  assign tmode = bts_pkg::bts_tout_t'(ctrl[bts_pkg::ctrl_tout_lsb +: 2]);
  assign hmode = bts_pkg::bts_hold_t'(ctrl[bts_pkg::ctrl_hold_lsb +: 2]);
  assign gated = ctrl[bts_pkg::ctrl_gated_bit];
  assign infinite = ctrl[bts_pkg::ctrl_inf_bit];

  // *************************
  // apb slave
  // *************************
  // zero wait states; unmapped addresses answer with pslverr
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  always_comb
  begin
    hit = 1'b1;
    case (paddr)
      bts_pkg::ctrl_off: hit = 1'b1;
      bts_pkg::ncyc_off: hit = 1'b1;
      bts_pkg::per_off: hit = 1'b1;
      bts_pkg::dly_off: hit = 1'b1;
      bts_pkg::cnt_off: hit = 1'b1;
      bts_pkg::phase_off: hit = 1'b1;
      bts_pkg::offs_off: hit = 1'b1;
      bts_pkg::mtrig_off: hit = 1'b1;
      bts_pkg::stat_off: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= bts_pkg::ctrl_rst;
      ncyc <= bts_pkg::ncyc_rst;
      per <= bts_pkg::per_rst;
      dly <= bts_pkg::min_dly;
      cnt <= bts_pkg::cnt_rst;
      phase <= 32'h0;
      offs <= 32'h0;
    end
    else if (wr)
    begin
      case (paddr)
        bts_pkg::ctrl_off: ctrl <= pwdata;
        bts_pkg::ncyc_off: ncyc <= pwdata;
        bts_pkg::per_off: per <= pwdata;
        // delays below hardware latency are raised to it
        bts_pkg::dly_off: dly <= (pwdata < bts_pkg::min_dly) ?
          bts_pkg::min_dly : pwdata;
        bts_pkg::cnt_off: cnt <= pwdata;
        bts_pkg::phase_off: phase <= pwdata;
        bts_pkg::offs_off: offs <= pwdata;
        default: ;
      endcase
    end
  end

  // manual trigger is a one-cycle pulse from a write of bit 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      man_req <= 1'b0;
    else
      man_req <= wr && paddr == bts_pkg::mtrig_off && pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        bts_pkg::ctrl_off: prdata <= ctrl;
        bts_pkg::ncyc_off: prdata <= ncyc;
        bts_pkg::per_off: prdata <= per;
        bts_pkg::dly_off: prdata <= dly;
        bts_pkg::cnt_off: prdata <= cnt;
        bts_pkg::phase_off: prdata <= phase;
        bts_pkg::offs_off: prdata <= offs;
        bts_pkg::stat_off: prdata <= {28'h0, gate_on, wave_active,
          busy, ext_q};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // *************************
  // trigger qualification
  // *************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_q <= 1'b0;
    else
      ext_q <= ext_in;
  end

  always_comb
  begin
    trig_ev = 1'b0;
    case (src)
      bts_pkg::src_ext: trig_ev = ctrl[bts_pkg::ctrl_fall_bit] ?
        (ext_q && !ext_in) : (!ext_q && ext_in);
      bts_pkg::src_man: trig_ev = man_req;
      default: trig_ev = 1'b0;
    endcase
  end

  // gate polarity selects active level
  assign gate_on = (ext_in == !ctrl[bts_pkg::ctrl_gpol_bit]);

  // *************************
  // burst sequencer
  // *************************
  assign busy = state != bts_pkg::st_idle;
  assign seq_start = car.load && !gated &&
    (state == bts_pkg::st_delay || src == bts_pkg::src_int);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= bts_pkg::st_idle;
      tmr <= 32'h0;
      cyc_left <= 32'h0;
      trains_left <= 32'h0;
    end
    else if (!ctrl[bts_pkg::ctrl_en_bit] || gated)
    begin
      state <= bts_pkg::st_idle;
    end
    else
    begin
      case (state)
        bts_pkg::st_idle:
        begin
          // internal source runs free; others wait for a trigger
          if (src == bts_pkg::src_int || trig_ev)
          begin
            state <= bts_pkg::st_delay;
            tmr <= dly;
            trains_left <= (src == bts_pkg::src_int) ? 32'h1 : cnt;
          end
        end
        bts_pkg::st_delay:
        begin
          tmr <= dec(tmr);
          if (tmr <= 32'h1)
          begin
            state <= bts_pkg::st_burst;
            cyc_left <= ncyc;
          end
        end
        bts_pkg::st_burst:
        begin
          // stop only at a carrier wrap, so cycles stay whole
          if (car.wrap && !infinite)
          begin
            cyc_left <= dec(cyc_left);
            if (cyc_left <= 32'h1)
            begin
              trains_left <= dec(trains_left);
              if (src == bts_pkg::src_int || trains_left > 32'h1)
                state <= bts_pkg::st_gap;
              else
                state <= bts_pkg::st_idle;
            end
          end
        end
        bts_pkg::st_gap:
        begin
          // next head comes one burst period after the last one
          if (per_tmr <= 32'h1)
          begin
            state <= bts_pkg::st_burst;
            cyc_left <= ncyc;
          end
        end
        default: state <= bts_pkg::st_idle;
      endcase
    end
  end

  // burst period timer counts from each burst start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      per_tmr <= 32'h0;
    else if (car.load)
      per_tmr <= per;
    else
      per_tmr <= dec(per_tmr);
  end

  // *************************
  // carrier control
  // *************************
  // load start phase at every burst head, including gate openings
  always_comb
  begin
    car.load = 1'b0;
    car.run = 1'b0;
    if (gated)
    begin
      car.load = ctrl[bts_pkg::ctrl_en_bit] && !gate_on;
      car.run = ctrl[bts_pkg::ctrl_en_bit] && gate_on;
    end
    else
    begin
      car.load = (state == bts_pkg::st_delay && tmr <= 32'h1) ||
        (state == bts_pkg::st_gap && per_tmr <= 32'h1);
      car.run = state == bts_pkg::st_burst;
    end
    car.phase = phase;
    car.step = carrier_step;
  end

  // last carrier sample of a burst, for the end hold value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      end_sample <= 32'h0;
    else if (car.run)
      end_sample <= car.sample;
  end

  // *************************
  // outputs
  // *************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wave_out <= 32'h0;
      wave_active <= 1'b0;
    end
    else
    begin
      wave_active <= car.run;
      if (car.run)
        wave_out <= car.sample;
      else
      begin
        case (hmode)
          bts_pkg::hold_start: wave_out <= phase;
          bts_pkg::hold_end: wave_out <= end_sample;
          bts_pkg::hold_mid: wave_out <= offs;
          default: wave_out <= phase;
        endcase
      end
    end
  end

  // trigger output rises (up) or falls (down) at sequence start and turns back half a burst period after each burst start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_out <= 1'b0;
    else if (src == bts_pkg::src_ext || tmode == bts_pkg::tout_off)
      trig_out <= 1'b0;
    else if (seq_start)
      trig_out <= (tmode == bts_pkg::tout_up);
    else if (per_tmr == {1'b0, per[31:1]})
      trig_out <= (tmode != bts_pkg::tout_up);
  end

endmodule // bts_sequencer

/* tb/bts_chk.sv */
// port checker of the burst trigger sequencer
`timescale 1ns/10ps
module bts_chk
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // link
  input wire logic ext_in,
  input wire logic [31:0] wave_out,
  input wire logic wave_active,
  input wire logic trig_out
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [10:0] ctl;
  logic [31:0] ph;
  logic [31:0] ofs;
  logic [1:0] qt;
  logic [2:0] gn;
  logic wr;
  logic q3;
  logic bad;
  assign wr = psel && penable && pwrite;
  assign q3 = qt == 2'h3;
  assign bad = psel && penable && paddr > 12'h020;
  // ****************
  // mirror of writes
  // ****************
  // a setting is trusted only three cycles after its write lands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl <= '0;
      ph <= '0;
      ofs <= '0;
      qt <= '0;
      gn <= '0;
    end
    else
    begin
      if (wr && paddr == 12'h000)
        ctl <= pwdata[10:0];
      if (wr && paddr == 12'h014)
        ph <= pwdata;
      if (wr && paddr == 12'h018)
        ofs <= pwdata;
      qt <= wr ? 2'h0 : (q3 ? qt : qt + 2'h1);
      gn <= (ext_in != ctl[4]) ? 3'h0 : (gn == 3'h7 ? gn : gn + 3'h1);
    end
  end
  // ****************
  // properties
  // ****************
  a_ready_zero: assert property (psel && penable |-> pready)
    else $error("access phase not answered at once");
  a_unmapped_err: assert property (bad |-> pslverr)
    else $error("unmapped access not flagged");
  a_unmapped_zero: assert property (bad && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_start_phase: assert property (
    q3 && $rose(wave_active) |-> wave_out == ph)
    else $error("burst not at start phase");
  a_trig_off: assert property (
    q3 && ctl[7:6] == 2'h0 |-> !trig_out)
    else $error("trigger output active while off");
  a_trig_edge: assert property (
    q3 && ctl[7:6] != 2'h0 && ctl[3:2] == 2'h0 && $rose(wave_active)
    |-> trig_out == !ctl[7])
    else $error("trigger edge not at burst start");
  a_inf_run: assert property (
    q3 && ctl[10] && !ctl[1] && ctl[0] && wave_active |=> wave_active)
    else $error("infinite burst stopped");
  a_hold_ofs: assert property (
    q3 && ctl[9:8] == 2'h2 && !wave_active && !$past(wave_active)
    && !$past(wave_active, 2) |-> wave_out == ofs)
    else $error("hold level not offset");
  a_gate_block: assert property (
    q3 && ctl[1] && ctl[3:2] == 2'h1 && gn == 3'h7 |-> !wave_active)
    else $error("carrier passed with gate inactive");
  c_burst: cover property ($rose(wave_active));
  c_manual: cover property (wr && paddr == 12'h01c);
  c_gated: cover property (ctl[1] && wave_active);
endmodule // bts_chk
bind bts_sequencer bts_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_in(ext_in),
  .wave_out(wave_out), .wave_active(wave_active), .trig_out(trig_out));

/* tb/bts_sequencer_test.sv */
// self-checking testbench of the burst trigger sequencer
`timescale 1ns/10ps
module bts_sequencer_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, step, wave_out, rdat, ofs, ph;
  logic ext_in, lvl, slow, wave_active, trig_out, rerr, fe, gp;
  int fail_count, checks_done, rises, hi, tog, len, gap, nc, m, h;
  int cyc = 0;
  logic [31:0] rv [5] = '{bts_pkg::ctrl_rst, bts_pkg::ncyc_rst,
    bts_pkg::per_rst, bts_pkg::min_dly, bts_pkg::cnt_rst};
  bts_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_in(ext_in),
    .carrier_step(step), .wave_out(wave_out), .wave_active(wave_active),
    .trig_out(trig_out));
  bts_trig_src src (.pclk(pclk), .lvl(lvl), .slow(slow), .ext_in(ext_in));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] cw(int s, int t, int hv, int b);
    return 32'(b | s << 2 | t << 6 | hv << 8);
  endfunction
  // whole carrier cycles of 2^32 / step clocks each
  function automatic int blen(int n, logic [31:0] st);
    return n * int'(64'h1_0000_0000 / 64'(st));
  endfunction
  // hold level after whole cycles from phase zero: the last sample
  // of a burst sits one step short of a full turn
  function automatic logic [31:0] hold_exp(int hv, logic [31:0] o,
    logic [31:0] st);
    return hv == 2 ? o : (hv == 1 ? 32'h0 - st : 32'h0);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wait_wa(input logic v, output int t);
    for (t = 0; t < 3000 && wave_active !== v; t++)
      @(posedge pclk);
    if (t == 3000)
    begin
      fail_count++;
      $display("Error %0t: wave_active wait ran out", $time);
    end
  endtask
  task automatic watch(input int n);
    logic pa;
    logic pt;
    rises = 0;
    hi = 0;
    tog = 0;
    pa = wave_active;
    pt = trig_out;
    repeat (n)
    begin
      @(posedge pclk);
      rises += int'(wave_active && !pa);
      hi += int'(wave_active);
      tog += int'(trig_out != pt);
      pa = wave_active;
      pt = trig_out;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fail_count++;
      $display("Error %0t: run timed out", $time);
      close_out();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    {presetn, psel, penable, pwrite, lvl, slow} = '0;
    paddr = '0;
    pwdata = '0;
    step = 32'h1000_0000;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(68));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (m = 0; m < 5; m++)
    begin
      apb(1'b0, 12'(4 * m), 32'h0);
      chk(rdat, rv[m]);
    end
    apb(1'b0, 12'h024, 32'h0);
    chk(32'(rerr), 32'h1);
    chk(rdat, 32'h0);
    $display("test reset done");
    ofs = $urandom;
    apb(1'b1, bts_pkg::per_off, 32'd300);
    apb(1'b1, bts_pkg::phase_off, 32'h0);
    apb(1'b1, bts_pkg::offs_off, ofs);
    for (m = 0; m < 3; m++)
    begin
      apb(1'b1, bts_pkg::ctrl_off, 32'h0);
      wait_wa(1'b0, len);
      nc = $urandom_range(1, 3);
      h = $urandom_range(0, 2);
      step <= 32'h0400_0000 << $urandom_range(0, 2);
      apb(1'b1, bts_pkg::ncyc_off, 32'(nc));
      apb(1'b1, bts_pkg::ctrl_off, cw(0, m, h, 1));
      wait_wa(1'b1, len);
      wait_wa(1'b0, len);
      chk(32'(len), 32'(blen(nc, step)));
      repeat (3) @(posedge pclk);
      chk(wave_out, hold_exp(h, ofs, step));
      wait_wa(1'b1, gap);
      chk(32'(trig_out), 32'(m == 1));
      chk(32'(len + gap + 3), 32'd300);
      watch(600);
      chk(32'(tog != 0), 32'(m != 0));
    end
    $display("test internal done");
    apb(1'b1, bts_pkg::ctrl_off, 32'h0);
    wait_wa(1'b0, len);
    apb(1'b1, bts_pkg::dly_off, 32'h1);
    apb(1'b0, bts_pkg::dly_off, 32'h0);
    chk(rdat, bts_pkg::min_dly);
    apb(1'b1, bts_pkg::cnt_off, 32'h3);
    apb(1'b1, bts_pkg::ctrl_off, cw(2, 1, 0, 1));
    apb(1'b1, bts_pkg::mtrig_off, 32'h1);
    wait_wa(1'b1, len);
    chk(32'(len >= 4 && len <= 12), 32'h1);
    apb(1'b1, bts_pkg::mtrig_off, 32'h1);
    watch(1200);
    chk(32'(rises), 32'h2);
    apb(1'b1, bts_pkg::mtrig_off, 32'h1);
    watch(1200);
    chk(32'(rises), 32'h3);
    $display("test manual done");
    fe = 1'($urandom_range(0, 1));
    slow <= 1'($urandom_range(0, 1));
    apb(1'b1, bts_pkg::cnt_off, 32'h1);
    apb(1'b1, bts_pkg::ctrl_off, cw(1, 0, 0, 1 | 32'(fe) << 5));
    lvl <= 1'b1;
    watch(60);
    chk(32'(rises), 32'(!fe));
    lvl <= 1'b0;
    watch(60);
    chk(32'(rises), 32'(fe));
    wait_wa(1'b0, len);
    $display("test external done");
    gp = 1'($urandom_range(0, 1));
    lvl <= gp;
    apb(1'b1, bts_pkg::ctrl_off, cw(1, 0, 0, 3 | 32'(gp) << 4));
    watch(40);
    chk(32'(hi), 32'h0);
    lvl <= !gp;
    watch(300);
    chk(32'(hi >= 280), 32'h1);
    lvl <= gp;
    watch(40);
    chk(32'(hi <= 10), 32'h1);
    $display("test gated done");
    ph = $urandom;
    apb(1'b1, bts_pkg::ctrl_off, 32'h0);
    apb(1'b1, bts_pkg::phase_off, ph);
    apb(1'b0, bts_pkg::phase_off, 32'h0);
    chk(rdat, ph);
    apb(1'b1, bts_pkg::ctrl_off, cw(2, 0, 0, 1 | 1 << 10));
    apb(1'b1, bts_pkg::mtrig_off, 32'h1);
    wait_wa(1'b1, len);
    chk(wave_out, ph);
    watch(400);
    chk(32'(hi), 32'd400);
    apb(1'b1, bts_pkg::ctrl_off, 32'h0);
    $display("test infinite done");
    close_out();
  end
endmodule // bts_sequencer_test

/* tb/bts_trig_src.sv */
// external trigger and gate source model
`timescale 1ns/10ps
module bts_trig_src
(
  // clock
  input wire logic pclk,
  // request from bench
  input wire logic lvl,
  input wire logic slow,
  // driven line
  output logic ext_in
);
  logic lag;
  // a slow source answers one cycle later, like a long cable
  always_ff @(posedge pclk)
  begin
    lag <= lvl;
    ext_in <= slow ? lag : lvl;
  end
endmodule // bts_trig_src
